// File: rtl/acif_pkg.sv
// Package: register map, field positions, reset values and timing of the converter control block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package acif_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h34;
    localparam logic [7:0] IDX_RES_LO = 8'h35;
    localparam logic [7:0] IDX_RES_HI = 8'h36;
    localparam logic [7:0] IDX_IEN2 = 8'h3f;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h41;
    localparam logic [7:0] IDX_IRQ_EN = 8'h42;
    localparam int ADDR_W = 10;
    // Control register fields
    localparam int CTRL_CH_LSB = 0;
    localparam int CTRL_DONE_BIT = 4;
    // Second interrupt enable register fields
    localparam int IEN2_ADC_BIT = 6;
    localparam int IEN2_FIX0_BIT = 7;
    // Interrupt status fields
    localparam int IRQ_DONE_BIT = 0;
    // Reset values
    localparam logic [2:0] CH_RST = 3'h0;
    localparam logic DONE_RST = 1'b1;
    localparam logic [7:0] IEN2_RST = 8'h00;
    localparam logic [9:0] RES_RST = 10'h000;
    localparam logic [9:0] SAR_MSB = 10'h200;
    localparam logic [3:0] SAR_TOP_BIT = 4'h9;
    // Avalon responses
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Timing: comparator settle time per result bit
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS = 100;
    localparam int BIT_CYC_I = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] BIT_CYC = 8'(BIT_CYC_I < 1 ? 1 : BIT_CYC_I);
    // Converter states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } acif_state_t;
    // Analog front end controls
    typedef struct packed {
        logic [2:0] chan;
        logic [9:0] trial;
        logic busy;
    } acif_ana_t;
endpackage

// File: rtl/acif_top.sv
// Converter control block: channel select, successive approximation sequencer,
// result registers, interrupt enables and an Avalon-MM slave with waitrequest.
// Assumes an external analog mux, trial DAC and comparator answering within one bit time.
`timescale 1ns/1ps
module acif_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [acif_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic [1:0] avs_response,
    output logic avs_waitrequest,
    // Analog front end
    output acif_pkg::acif_ana_t ana_ctrl,
    input wire logic comp_above,
    // Interrupts
    output logic [7:0] int_enable_second,
    output logic irq
);
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    logic [2:0] chan_q;
    logic done_q;
    logic [7:0] ien2_q;
    logic [9:0] result_q;
    logic [9:0] trial_q;
    logic [3:0] bit_q;
    logic [7:0] cyc_q;
    logic stat_q;
    acif_pkg::acif_state_t st_q;

    // Bus decode
    wire logic req = avs_read | avs_write;
    wire logic take = req & ack_q;
    wire logic [7:0] idx = avs_address[acif_pkg::ADDR_W-1:2];
    wire logic lane0 = avs_byteenable[0];
    wire logic hit_ctrl = idx == acif_pkg::IDX_CTRL;
    wire logic hit_lo = idx == acif_pkg::IDX_RES_LO;
    wire logic hit_hi = idx == acif_pkg::IDX_RES_HI;
    wire logic hit_ien2 = idx == acif_pkg::IDX_IEN2;
    wire logic hit_stat = idx == acif_pkg::IDX_IRQ_STAT;
    wire logic hit_clr = idx == acif_pkg::IDX_IRQ_CLR;
    wire logic hit_en = idx == acif_pkg::IDX_IRQ_EN;
    wire logic mapped = hit_ctrl | hit_lo | hit_hi | hit_ien2 | hit_stat | hit_clr | hit_en;
    wire logic wr_ok = avs_write & take & lane0;
    wire logic wr_ctrl = wr_ok & hit_ctrl;
    wire logic wr_ien2 = wr_ok & hit_ien2;
    wire logic wr_en = wr_ok & hit_en;
    wire logic wr_clr = wr_ok & hit_clr;

    // Read views
    wire logic [7:0] ctrl_view = {3'b000, done_q, 1'b0, chan_q};
    wire logic [7:0] lo_view = result_q[7:0];
    wire logic [7:0] hi_view = {6'b00_0000, result_q[9:8]};
    wire logic [7:0] stat_view = {7'b000_0000, stat_q};
    wire logic [7:0] en_view = {7'b000_0000, ien2_q[acif_pkg::IEN2_ADC_BIT]};
    wire logic [7:0] rd_mux = hit_ctrl ? ctrl_view :
                              hit_lo ? lo_view :
                              hit_hi ? hi_view :
                              hit_ien2 ? ien2_q :
                              hit_stat ? stat_view :
                              hit_en ? en_view : 8'h00;

    // Sequencer decode
    wire logic step_end = (st_q == acif_pkg::ST_CONV) & (cyc_q == 8'h01);
    wire logic last_bit = bit_q == 4'h0;
    wire logic conv_done = step_end & last_bit & ~wr_ctrl;
    wire logic [9:0] bit_mask = 10'h001 << bit_q;
    wire logic [9:0] kept = comp_above ? trial_q : (trial_q & ~bit_mask);
    wire logic [9:0] next_trial = kept | (bit_mask >> 1);

    // One wait cycle per access, then the answer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            resp_q <= acif_pkg::RESP_OK;
        end else begin
            ack_q <= req & ~ack_q;
            rdata_q <= {24'h00_0000, rd_mux};
            resp_q <= mapped ? acif_pkg::RESP_OK : acif_pkg::RESP_SLVERR;
        end
    end

    // Control register and conversion start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chan_q <= acif_pkg::CH_RST;
            done_q <= acif_pkg::DONE_RST;
        end else if (wr_ctrl) begin
            chan_q <= avs_writedata[acif_pkg::CTRL_CH_LSB +: 3];
            done_q <= 1'b0;
        end else if (conv_done) begin
            done_q <= 1'b1;
        end
    end

    // Second interrupt enable register, bit 6 also reachable via the enable register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ien2_q <= acif_pkg::IEN2_RST;
        end else if (wr_ien2) begin
            ien2_q <= avs_writedata[7:0];
        end else if (wr_en) begin
            ien2_q[acif_pkg::IEN2_ADC_BIT] <= avs_writedata[acif_pkg::IRQ_DONE_BIT];
        end
    end

    // Sticky completion flag; a new completion beats a clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stat_q <= 1'b0;
        end else if (conv_done) begin
            stat_q <= 1'b1;
        end else if (wr_clr & avs_writedata[acif_pkg::IRQ_DONE_BIT]) begin
            stat_q <= 1'b0;
        end
    end

    // Successive approximation sequencer, MSB first, one bit time per step
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= acif_pkg::ST_IDLE;
            trial_q <= acif_pkg::RES_RST;
            bit_q <= acif_pkg::SAR_TOP_BIT;
            cyc_q <= acif_pkg::BIT_CYC;
            result_q <= acif_pkg::RES_RST;
        end else if (wr_ctrl) begin
            st_q <= acif_pkg::ST_CONV;
            trial_q <= acif_pkg::SAR_MSB;
            bit_q <= acif_pkg::SAR_TOP_BIT;
            cyc_q <= acif_pkg::BIT_CYC;
        end else begin
            case (st_q)
                acif_pkg::ST_IDLE: begin
                    cyc_q <= acif_pkg::BIT_CYC;
                end
                acif_pkg::ST_CONV: begin
                    if (!step_end) begin
                        cyc_q <= cyc_q - 8'h01;
                    end else if (last_bit) begin
                        st_q <= acif_pkg::ST_IDLE;
                        trial_q <= kept;
                        result_q <= kept;
                    end else begin
                        trial_q <= next_trial;
                        bit_q <= bit_q - 4'h1;
                        cyc_q <= acif_pkg::BIT_CYC;
                    end
                end
                default: begin
                    st_q <= acif_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Outputs
    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;
    assign ana_ctrl.chan = chan_q;
    assign ana_ctrl.trial = trial_q;
    assign ana_ctrl.busy = st_q == acif_pkg::ST_CONV;
    assign int_enable_second = ien2_q;
    assign irq = stat_q & ien2_q[acif_pkg::IEN2_ADC_BIT];
endmodule

// File: tb/acif_assertions.sv
// Checker for the converter control block, seeing only its top ports.
// Assumes acif_pkg and a bind from the bench top file.
`timescale 1ns/1ps
module acif_chk (
    // Watched ports
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [acif_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire acif_pkg::acif_ana_t ana_ctrl,
    input wire logic [7:0] int_enable_second,
    input wire logic irq
);
    wire [7:0] idx = avs_address[9:2];
    wire rd = avs_read && !avs_waitrequest;
    wire wr = avs_write && !avs_waitrequest && avs_byteenable[0];
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_ien_reset: assert property ($past(sys_rst) |-> int_enable_second == 8'h00)
        else $error("enable register not cleared");
    chk_ien_write: assert property (wr && idx == acif_pkg::IDX_IEN2
        |=> int_enable_second == $past(avs_writedata[7:0])) else $error("enable write lost");
    chk_irq_gate: assert property (irq |-> int_enable_second[6])
        else $error("interrupt while disabled");
    chk_irq_set: assert property ($fell(ana_ctrl.busy) && int_enable_second[6] |-> irq)
        else $error("no interrupt on completion");
    chk_conv_start: assert property (wr && idx == acif_pkg::IDX_CTRL |=> ana_ctrl.busy
        && ana_ctrl.chan == $past(avs_writedata[2:0]) && ana_ctrl.trial == acif_pkg::SAR_MSB)
        else $error("conversion start wrong");
    chk_conv_len: assert property ($rose(ana_ctrl.busy) |-> ##99 ana_ctrl.busy ##1 !ana_ctrl.busy)
        else $error("conversion length wrong");
    chk_ctrl_zero: assert property (rd && idx == acif_pkg::IDX_CTRL
        |-> avs_readdata[7:5] == 3'h0 && !avs_readdata[3]) else $error("control spare bits set");
    chk_high_zero: assert property (rd && idx == acif_pkg::IDX_RES_HI
        |-> avs_readdata[31:2] == '0) else $error("high result upper bits set");
endmodule

// File: tb/acif_sensor.sv
// Analog sensor model: a fixed level per channel, compared with the trial code.
// Assumes the front end controls of acif_top.
`timescale 1ns/1ps
module acif_sensor (
    // Front end
    input wire acif_pkg::acif_ana_t ana_ctrl,
    output logic comp_above
);
    wire [9:0] lvl = {ana_ctrl.chan, ana_ctrl.chan, 4'h9};
    // Outside a conversion the answer is inverted so a stale value is never right
    assign comp_above = ana_ctrl.busy ? lvl >= ana_ctrl.trial : lvl < ana_ctrl.trial;
endmodule

// File: tb/tb_acif_top.sv
// Bench for the converter control block with the sensor model on its front end.
// Assumes acif_pkg; the bench is the Avalon-MM master.
`timescale 1ns/1ps
module tb_acif_top;
    logic clk = 0;
    logic sys_rst = 1;
    logic [9:0] avs_address = '0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata, q;
    logic [1:0] avs_response, r;
    logic avs_waitrequest, comp_above, irq;
    acif_pkg::acif_ana_t ana_ctrl;
    logic [7:0] int_enable_second;
    int errors = 0;
    int checks_done = 0;
    acif_top i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_response(avs_response),
        .avs_waitrequest(avs_waitrequest), .ana_ctrl(ana_ctrl), .comp_above(comp_above),
        .int_enable_second(int_enable_second), .irq(irq));
    acif_sensor i_sensor (.ana_ctrl(ana_ctrl), .comp_above(comp_above));
    initial forever #5 clk = ~clk;
    task automatic final_report;
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] o);
        int n;
        n = 0;
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= {i, 2'b00};
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            final_report;
        end
        o = avs_readdata;
        r = avs_response;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic t_regs;
        bus(0, acif_pkg::IDX_CTRL, 0, q);
        chk("ctrl reset", 8'h10, q);
        bus(0, acif_pkg::IDX_IEN2, 0, q);
        chk("ien2 reset", 8'h00, q);
        bus(1, acif_pkg::IDX_IEN2, 8'h3f, q);
        bus(0, acif_pkg::IDX_IEN2, 0, q);
        chk("ien2", 8'h3f, q);
        chk("ien2 port", 8'h3f, int_enable_second);
        avs_byteenable <= 4'h0;
        bus(1, acif_pkg::IDX_IEN2, 8'h00, q);
        avs_byteenable <= 4'hf;
        bus(0, acif_pkg::IDX_IEN2, 0, q);
        chk("ien2 kept", 8'h3f, q);
        bus(0, 8'h20, 0, q);
        chk("unmapped", 2'b10, r);
    endtask
    task automatic t_conv;
        logic [9:0] v;
        for (int c = 0; c < 8; c++) begin
            v = {c[2:0], c[2:0], 4'h9};
            bus(1, acif_pkg::IDX_CTRL, {5'h1f, c[2:0]}, q);
            bus(0, acif_pkg::IDX_CTRL, 0, q);
            chk("ctrl busy", {29'h0, c[2:0]}, q);
            chk("chan", c[2:0], ana_ctrl.chan);
            repeat (60) if (q[4] !== 1'b1) bus(0, acif_pkg::IDX_CTRL, 0, q);
            chk("ctrl done", {27'h0, 2'b10, c[2:0]}, q);
            bus(0, acif_pkg::IDX_RES_LO, 0, q);
            chk("result low", v[7:0], q);
            bus(1, acif_pkg::IDX_RES_HI, 8'hff, q);
            bus(0, acif_pkg::IDX_RES_HI, 0, q);
            chk("result high", v[9:8], q);
        end
    endtask
    task automatic t_irq;
        bus(1, acif_pkg::IDX_IEN2, 8'h40, q);
        bus(1, acif_pkg::IDX_CTRL, 8'h03, q);
        repeat (110) @(posedge clk);
        chk("irq on", 1'b1, irq);
        bus(0, acif_pkg::IDX_IRQ_STAT, 0, q);
        chk("status", 8'h01, q);
        bus(1, acif_pkg::IDX_IEN2, 8'h00, q);
        @(posedge clk);
        chk("irq masked", 1'b0, irq);
        bus(1, acif_pkg::IDX_IRQ_CLR, 8'h01, q);
        bus(1, acif_pkg::IDX_IEN2, 8'h40, q);
        @(posedge clk);
        chk("irq cleared", 1'b0, irq);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 0;
        t_regs;
        t_conv;
        t_irq;
        final_report;
    end
    initial begin
        #200000;
        errors++;
        final_report;
    end
endmodule
bind acif_top acif_chk i_chk (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ana_ctrl(ana_ctrl),
    .int_enable_second(int_enable_second), .irq(irq));
